// ==== rtl/bpn_map.vh ====
`ifndef BPN_MAP_VH
`define BPN_MAP_VH

// ----------------------------------------------------------------------------
// Datapath widths
// ----------------------------------------------------------------------------
`define BPN_DATA_W 32
`define BPN_LKP_W 27
`define BPN_ADD_W 22
`define BPN_CTL_W 8
`define BPN_SH_W 5

// ----------------------------------------------------------------------------
// Register selects on the host port
// ----------------------------------------------------------------------------
`define BPN_SEL_LOOKUP_SCALE 1'b0
`define BPN_SEL_NORMALISE 1'b1

// ----------------------------------------------------------------------------
// lookup_scale_control fields
// ----------------------------------------------------------------------------
`define BPN_LSC_PRE_HI 4
`define BPN_LSC_PRE_LO 0
`define BPN_LSC_PASS_MS 5
`define BPN_LSC_PASS_LS 6
`define BPN_LSC_RSVD 7

// ----------------------------------------------------------------------------
// normalise_control fields
// ----------------------------------------------------------------------------
`define BPN_NC_SH_HI 7
`define BPN_NC_SH_LO 3
`define BPN_NC_DYN 2
`define BPN_NC_FEED 1
`define BPN_NC_RSVD 0

// ----------------------------------------------------------------------------
// Lookup table output fields
// ----------------------------------------------------------------------------
`define BPN_LKP_SH_HI 26
`define BPN_LKP_SH_LO 22
`define BPN_LKP_ADD_HI 21
`define BPN_LKP_ADD_LO 0

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define BPN_CTL_RESET 8'h00
`define BPN_SH_RESET 5'h00
`define BPN_SH_ONE 5'h01
`define BPN_NORM_MAX_POS 5'h0E
`define BPN_NORM_MINUS_ONE 5'h1F
`define BPN_NORM_MINUS_TWO 5'h1E
`define BPN_DATA_ZERO 32'h00000000
`define BPN_ADD_ZERO 22'h000000
`define BPN_LKP_ZERO 27'h0000000

`endif

// ==== rtl/bpn_norm_shift.v ====
`include "bpn_map.vh"

module bpn_norm_shift (
    ref_clk,
    sys_rst,
    shiftIn,
    shiftCode,
    shiftInValid,
    shiftOut,
    shiftOutValid
);
    input wire ref_clk;
    input wire sys_rst;
    input wire [`BPN_DATA_W-1:0] shiftIn;
    input wire [`BPN_SH_W-1:0] shiftCode;
    input wire shiftInValid;
    output reg [`BPN_DATA_W-1:0] shiftOut;
    output reg shiftOutValid;

    // ------------------------------------------------------------------------
    // Two's complement shift: positive right, negative left
    // ------------------------------------------------------------------------
    function [`BPN_DATA_W-1:0] normShift;
        input [`BPN_DATA_W-1:0] d;
        input [`BPN_SH_W-1:0] c;
        reg [`BPN_SH_W-1:0] mag;
        begin
            mag = (~c) + `BPN_SH_ONE;
            if (!c[`BPN_SH_W-1] && (c <= `BPN_NORM_MAX_POS)) begin
                normShift = $signed(d) >>> c; // RL3 RL4 RL12
            end else if ((c == `BPN_NORM_MINUS_ONE) || (c == `BPN_NORM_MINUS_TWO)) begin
                normShift = d << mag; // RL3 RL4 RL12
            end else begin
                normShift = `BPN_DATA_ZERO; // RL5
            end
        end
    endfunction

    // Result is registered so the top's output comes straight from a flop
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shiftOut <= `BPN_DATA_ZERO;
            shiftOutValid <= 1'b0;
        end else begin
            shiftOut <= normShift(shiftIn, shiftCode);
            shiftOutValid <= shiftInValid;
        end
    end

endmodule

// ==== rtl/bpn_stage.v ====
`include "bpn_map.vh"

// Behaviour
// RL1 - Prescaler arithmetically right-shifts input by its five-bit field, zero to sixteen.
// RL2 - Host writes only zero to sixteen into the prescaler field.
// RL3 - Normaliser shift code is two's complement: positive right, negative left.
// RL4 - Normaliser codes minus two through plus fourteen are applied as given.
// RL5 - Normaliser codes outside minus two to plus fourteen output zero.
// RL6 - Dynamic bit set takes shift code from lookup bits 26 to 22.
// RL7 - Adder operand is zero, or lookup bits 21 to 0 when feed set.
// RL8 - Reserved low bit of normalise control reads zero; host writes zero.
// RL9 - Shift fields, dynamic bit and feed bit reset to zero.
// RL10 - Lookup disabled forces the static shift field regardless of dynamic bit.
// RL11 - Lookup disabled presents zero lookup output to the datapath.
// RL12 - Left shifts fill zeros; right shifts replicate the sign bit.
// RL13 - Control writes act from the edge after the write; in-flight data untouched.
module bpn_stage (
    ref_clk,
    sys_rst,
    hostWrEn,
    hostRdEn,
    hostSel,
    hostWrData,
    hostRdData,
    lookupEnable,
    prescaleIn,
    prescaleInValid,
    prescaleOut,
    prescaleOutValid,
    normIn,
    normInValid,
    lookupData,
    normOut,
    normOutValid,
    adderOperand,
    passLookupLs,
    passLookupMs
);
    input wire ref_clk;
    input wire sys_rst;
    input wire hostWrEn;
    input wire hostRdEn;
    input wire hostSel;
    input wire [`BPN_CTL_W-1:0] hostWrData;
    output reg [`BPN_CTL_W-1:0] hostRdData;
    input wire lookupEnable;
    input wire [`BPN_DATA_W-1:0] prescaleIn;
    input wire prescaleInValid;
    output reg [`BPN_DATA_W-1:0] prescaleOut;
    output reg prescaleOutValid;
    input wire [`BPN_DATA_W-1:0] normIn;
    input wire normInValid;
    input wire [`BPN_LKP_W-1:0] lookupData;
    output wire [`BPN_DATA_W-1:0] normOut;
    output wire normOutValid;
    output reg [`BPN_ADD_W-1:0] adderOperand;
    output wire passLookupLs;
    output wire passLookupMs;

    // ------------------------------------------------------------------------
    // Control register storage
    // ------------------------------------------------------------------------
    reg [`BPN_SH_W-1:0] preShift_q;
    reg passLs_q;
    reg passMs_q;
    reg [`BPN_SH_W-1:0] normShift_q;
    reg dynNorm_q;
    reg feedAdder_q;

    wire [`BPN_LKP_W-1:0] lookupSeen;
    wire [`BPN_SH_W-1:0] normCode;
    reg [`BPN_CTL_W-1:0] rdData_d;

    // ------------------------------------------------------------------------
    // Register image as software sees it
    // ------------------------------------------------------------------------
    // Reserved positions are packed as constant zeros so no read can leak them
    function [`BPN_CTL_W-1:0] lookupScaleImage;
        input [`BPN_SH_W-1:0] pre;
        input ls;
        input ms;
        begin
            lookupScaleImage = `BPN_CTL_RESET;
            lookupScaleImage[`BPN_LSC_PRE_HI:`BPN_LSC_PRE_LO] = pre;
            lookupScaleImage[`BPN_LSC_PASS_MS] = ms;
            lookupScaleImage[`BPN_LSC_PASS_LS] = ls;
            lookupScaleImage[`BPN_LSC_RSVD] = 1'b0;
        end
    endfunction

    function [`BPN_CTL_W-1:0] normaliseImage;
        input [`BPN_SH_W-1:0] sh;
        input dyn;
        input feed;
        begin
            normaliseImage = `BPN_CTL_RESET;
            normaliseImage[`BPN_NC_SH_HI:`BPN_NC_SH_LO] = sh;
            normaliseImage[`BPN_NC_DYN] = dyn;
            normaliseImage[`BPN_NC_FEED] = feed;
            normaliseImage[`BPN_NC_RSVD] = 1'b0; // RL8
        end
    endfunction

    // ------------------------------------------------------------------------
    // Write decode and field extraction
    // ------------------------------------------------------------------------
    // Each register has its own strobe, so a write to one never touches the other
    wire wrLookupScale;
    wire wrNormalise;
    wire [`BPN_SH_W-1:0] wrPreShift;
    wire wrPassMs;
    wire wrPassLs;
    wire [`BPN_SH_W-1:0] wrNormShift;
    wire wrDynNorm;
    wire wrFeedAdder;

    assign wrLookupScale = hostWrEn && (hostSel == `BPN_SEL_LOOKUP_SCALE);
    assign wrNormalise = hostWrEn && (hostSel == `BPN_SEL_NORMALISE);
    assign wrPreShift = hostWrData[`BPN_LSC_PRE_HI:`BPN_LSC_PRE_LO];
    assign wrPassMs = hostWrData[`BPN_LSC_PASS_MS];
    assign wrPassLs = hostWrData[`BPN_LSC_PASS_LS];
    assign wrNormShift = hostWrData[`BPN_NC_SH_HI:`BPN_NC_SH_LO];
    assign wrDynNorm = hostWrData[`BPN_NC_DYN];
    assign wrFeedAdder = hostWrData[`BPN_NC_FEED];

    // ------------------------------------------------------------------------
    // Host writes
    // ------------------------------------------------------------------------
    // Datapath reads only the stored copies, so a write takes hold one edge
    // later and never reshapes a word already latched in a pipeline stage.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            preShift_q <= `BPN_SH_RESET; // RL9
            passLs_q <= 1'b0;
            passMs_q <= 1'b0;
            normShift_q <= `BPN_SH_RESET; // RL9
            dynNorm_q <= 1'b0; // RL9
            feedAdder_q <= 1'b0; // RL9
        end else begin
            if (wrLookupScale) begin
                preShift_q <= wrPreShift; // RL13
                passMs_q <= wrPassMs;
                passLs_q <= wrPassLs;
            end
            if (wrNormalise) begin
                normShift_q <= wrNormShift; // RL13
                dynNorm_q <= wrDynNorm;
                feedAdder_q <= wrFeedAdder;
            end
        end
    end

    assign passLookupLs = passLs_q;
    assign passLookupMs = passMs_q;

    // ------------------------------------------------------------------------
    // Host reads
    // ------------------------------------------------------------------------
    always @* begin
        if (hostSel == `BPN_SEL_LOOKUP_SCALE) begin
            rdData_d = lookupScaleImage(preShift_q, passLs_q, passMs_q);
        end else begin
            rdData_d = normaliseImage(normShift_q, dynNorm_q, feedAdder_q); // RL8
        end
    end

    // Read data holds until the next read strobe
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hostRdData <= `BPN_CTL_RESET;
        end else if (hostRdEn) begin
            hostRdData <= rdData_d;
        end
    end

    // ------------------------------------------------------------------------
    // Lookup prescaler
    // ------------------------------------------------------------------------
    // Codes above sixteen are the host's fault; they simply shift further,
    // which costs nothing and keeps the output defined.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescaleOut <= `BPN_DATA_ZERO;
            prescaleOutValid <= 1'b0;
        end else begin
            prescaleOut <= $signed(prescaleIn) >>> preShift_q; // RL1
            prescaleOutValid <= prescaleInValid;
        end
    end

    // ------------------------------------------------------------------------
    // Lookup output gating and shift code selection
    // ------------------------------------------------------------------------
    // The table belongs to host memory access while disabled
    assign lookupSeen = lookupEnable ? lookupData : `BPN_LKP_ZERO; // RL11

    assign normCode = (lookupEnable && dynNorm_q) ?
        lookupSeen[`BPN_LKP_SH_HI:`BPN_LKP_SH_LO] : // RL6
        normShift_q; // RL10

    // ------------------------------------------------------------------------
    // Normaliser
    // ------------------------------------------------------------------------
    bpn_norm_shift uNormShift (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .shiftIn(normIn),
        .shiftCode(normCode), // RL3
        .shiftInValid(normInValid),
        .shiftOut(normOut),
        .shiftOutValid(normOutValid)
    );

    // ------------------------------------------------------------------------
    // Output adder operand
    // ------------------------------------------------------------------------
    // Registered in the same cycle as the normaliser so both stay aligned
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            adderOperand <= `BPN_ADD_ZERO;
        end else if (feedAdder_q) begin
            adderOperand <= lookupSeen[`BPN_LKP_ADD_HI:`BPN_LKP_ADD_LO]; // RL7
        end else begin
            adderOperand <= `BPN_ADD_ZERO; // RL7
        end
    end

endmodule

// ==== verification/bpn_stage_props.sv ====
module bpn_stage_props (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hostWrEn,
    input wire logic hostRdEn,
    input wire logic hostSel,
    input wire logic [7:0] hostWrData,
    input wire logic [7:0] hostRdData,
    input wire logic lookupEnable,
    input wire logic [31:0] prescaleIn,
    input wire logic prescaleInValid,
    input wire logic [31:0] prescaleOut,
    input wire logic prescaleOutValid,
    input wire logic [31:0] normIn,
    input wire logic normInValid,
    input wire logic [26:0] lookupData,
    input wire logic [31:0] normOut,
    input wire logic normOutValid,
    input wire logic [21:0] adderOperand,
    input wire logic passLookupLs,
    input wire logic passLookupMs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lscQ;
    logic [7:0] ncQ;
    logic [4:0] code;
    logic [31:0] preExp;
    logic [31:0] normExp;
    logic [21:0] addExp;
    logic [7:0] rdExp;
    function automatic logic [31:0] nrm(input logic [31:0] d, input logic [4:0] c);
        if (c <= 5'h0E) return $signed(d) >>> c;
        if (c == 5'h1F) return d << 1;
        if (c == 5'h1E) return d << 2;
        return 32'h00000000;
    endfunction
    // -------------------------------------------------------------------
    // Shadow of the control registers, as the host wrote them
    // -------------------------------------------------------------------
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lscQ <= 8'h00;
            ncQ <= 8'h00;
        end else if (hostWrEn && hostSel) begin
            ncQ <= hostWrData;
        end else if (hostWrEn) begin
            lscQ <= hostWrData;
        end
    end
    assign code = (lookupEnable && ncQ[2]) ? lookupData[26:22] : ncQ[7:3];
    assign normExp = nrm(normIn, code);
    assign preExp = $signed(prescaleIn) >>> lscQ[4:0];
    assign addExp = (lookupEnable && ncQ[1]) ? lookupData[21:0] : 22'h000000;
    assign rdExp = hostSel ? {ncQ[7:1], 1'b0} : {1'b0, lscQ[6:0]};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_pre;
        prescaleInValid |=> prescaleOut == $past(preExp);
    endproperty
    a_pre: assert property (p_pre) else $error("prescaler result wrong");
    property p_norm;
        normInValid |=> normOut == $past(normExp);
    endproperty
    a_norm: assert property (p_norm) else $error("normaliser result wrong");
    property p_add;
        normInValid |=> adderOperand == $past(addExp);
    endproperty
    a_add: assert property (p_add) else $error("adder operand wrong");
    property p_valid;
        1'b1 |=> normOutValid == $past(normInValid) && prescaleOutValid == $past(prescaleInValid);
    endproperty
    a_valid: assert property (p_valid) else $error("valid not one cycle behind");
    property p_rd;
        hostRdEn |=> hostRdData == $past(rdExp);
    endproperty
    a_rd: assert property (p_rd) else $error("register read wrong");
    property p_rd_hold;
        !hostRdEn |=> $stable(hostRdData);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_pass;
        passLookupLs == lscQ[6] && passLookupMs == lscQ[5];
    endproperty
    a_pass: assert property (p_pass) else $error("pass bits wrong");
    property p_rst;
        $fell(sys_rst) |-> normOut == 32'h00000000 && adderOperand == 22'h000000 && hostRdData == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule

// ==== verification/bpn_up_model.sv ====
module bpn_up_model (
    input wire logic ref_clk,
    output logic [31:0] sample,
    output logic [26:0] lookup,
    output logic valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sample = 32'h00000000;
        lookup = 27'h0000000;
        valid = 1'b0;
    end
    task send(input logic [31:0] d, input logic [26:0] l);
        @(posedge ref_clk);
        sample <= d;
        lookup <= l;
        valid <= 1'b1;
    endtask
    // Idle lines keep moving so a stale value can never pass for data
    task idle();
        @(posedge ref_clk);
        sample <= ~sample;
        lookup <= ~lookup;
        valid <= 1'b0;
    endtask
endmodule

// ==== verification/bpn_stage_test.sv ====
module bpn_stage_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hostWrEn = 1'b0;
    logic hostRdEn = 1'b0;
    logic hostSel = 1'b0;
    logic [7:0] hostWrData = 8'h00;
    logic lkEn = 1'b0;
    logic [4:0] pre = 5'h00;
    logic [7:0] nc = 8'h00;
    logic [31:0] sample;
    logic [26:0] lookup;
    logic valid;
    wire [7:0] hostRdData;
    wire [31:0] prescaleOut;
    wire [31:0] normOut;
    wire [21:0] adderOperand;
    int errorCnt = 0;
    int comparisons = 0;
    int cycles = 0;
    bpn_up_model m (.ref_clk(ref_clk), .sample(sample), .lookup(lookup), .valid(valid));
    bpn_stage dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
        .hostSel(hostSel), .hostWrData(hostWrData), .hostRdData(hostRdData), .lookupEnable(lkEn),
        .prescaleIn(sample), .prescaleInValid(valid), .prescaleOut(prescaleOut), .prescaleOutValid(),
        .normIn(sample), .normInValid(valid), .lookupData(lookup), .normOut(normOut), .normOutValid(),
        .adderOperand(adderOperand), .passLookupLs(), .passLookupMs());
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] nexp(input logic [31:0] d, input logic [4:0] c);
        if (c <= 5'h0E) return $signed(d) >>> c;
        if (c == 5'h1F) return d << 1;
        if (c == 5'h1E) return d << 2;
        return 32'h00000000;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task stopTest();
        $display("comparisons %0d, mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // -------------------------------------------------------------------
    // Host register port
    // -------------------------------------------------------------------
    task wr(input logic sel, input logic [7:0] d);
        @(posedge ref_clk);
        hostWrEn <= 1'b1;
        hostSel <= sel;
        hostWrData <= d;
        @(posedge ref_clk);
        hostWrEn <= 1'b0;
        if (sel) nc = d;
        else pre = d[4:0];
    endtask
    task rd(input logic sel, input logic [7:0] exp);
        @(posedge ref_clk);
        hostRdEn <= 1'b1;
        hostSel <= sel;
        @(posedge ref_clk);
        hostRdEn <= 1'b0;
        #1;
        chk({24'h000000, hostRdData}, {24'h000000, exp});
    endtask
    // One sample through both shifters; results stand for one cycle only
    task xfer(input logic [31:0] d, input logic [26:0] l);
        logic [4:0] c;
        m.send(d, l);
        m.idle();
        #1;
        c = (lkEn && nc[2]) ? l[26:22] : nc[7:3];
        chk(prescaleOut, $signed(d) >>> pre);
        chk(normOut, nexp(d, c));
        chk({10'h000, adderOperand}, (lkEn && nc[1]) ? {10'h000, l[21:0]} : 32'h00000000);
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errorCnt++;
            stopTest();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(1'b0, 8'h00);
        rd(1'b1, 8'h00);
        $display("reset test done");
        for (int n = 0; n <= 16; n++) begin
            wr(1'b0, 8'h60 | n[7:0]);
            xfer(32'h87654321, 27'h0000000);
        end
        rd(1'b0, 8'h70);
        // Write and sample taken on one edge: the sample keeps the old shift
        fork
            wr(1'b0, 8'h63);
            m.send(32'h80000000, 27'h0000000);
        join
        #1;
        chk(prescaleOut, 32'hFFFF8000);
        m.idle();
        #1;
        chk(prescaleOut, 32'hF0000000);
        $display("prescale test done");
        for (int c = 0; c < 32; c++) begin
            wr(1'b1, {c[4:0], 3'b110});
            xfer(32'hC0FF00F1, 27'h7FFFFFF);
        end
        rd(1'b1, 8'hFE);
        $display("static normalise test done");
        @(posedge ref_clk);
        lkEn <= 1'b1;
        for (int c = 0; c < 32; c++) begin
            xfer(32'h80000001, {c[4:0], 22'h2AAAAA});
        end
        wr(1'b1, 8'h08);
        xfer(32'h80000001, {5'h1E, 22'h15555A});
        $display("dynamic normalise test done");
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        pre = 5'h00;
        nc = 8'h00;
        rd(1'b1, 8'h00);
        rd(1'b0, 8'h00);
        $display("second reset test done");
        stopTest();
    end
endmodule
bind bpn_stage bpn_stage_props chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .hostWrEn(hostWrEn),
    .hostRdEn(hostRdEn), .hostSel(hostSel), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .lookupEnable(lookupEnable), .prescaleIn(prescaleIn), .prescaleInValid(prescaleInValid),
    .prescaleOut(prescaleOut), .prescaleOutValid(prescaleOutValid), .normIn(normIn),
    .normInValid(normInValid), .lookupData(lookupData), .normOut(normOut), .normOutValid(normOutValid),
    .adderOperand(adderOperand), .passLookupLs(passLookupLs), .passLookupMs(passLookupMs));
